//--- core/lhs_pkg.sv
/*
 * Constants for the LIN slave sync detector: register map, field
 * positions, reset values and clock-rate counts.
 * Assumes a 25 MHz system clock; slower rates are derived as enables.
 */
package lhs_pkg;
   // Clock rates
   localparam int SYS_HZ = 25_000_000;
   localparam int SYNC_HZ = 5_000_000;
   localparam int LPOSC_HZ = 131_072;
   localparam int SYNC_DIV = SYS_HZ / SYNC_HZ;
   localparam int LP_DIV = SYS_HZ / LPOSC_HZ;

   // Register byte addresses
   localparam logic [31:0] ADDR_STATUS = 32'hffff0780;
   localparam logic [31:0] ADDR_CTRL = 32'hffff0784;
   localparam logic [31:0] ADDR_EDGE = 32'hffff0788;
   localparam logic [31:0] ADDR_SYNC_TMR = 32'hffff078c;
   localparam logic [31:0] ADDR_BRK_TMR = 32'hffff0790;
   localparam logic [31:0] ADDR_SYNC_CMP = 32'hffff0794;
   localparam logic [31:0] ADDR_BRK_CMP = 32'hffff0798;
   localparam logic [31:0] ADDR_IRQ_MASK = 32'hffff079c;
   localparam logic [31:0] ADDR_IRQ_STAT = 32'hffff07a0;
   localparam logic [31:0] ADDR_BAUD = 32'hffff07a4;

   // Status bit positions
   localparam int ST_BREAK = 0;
   localparam int ST_START = 1;
   localparam int ST_STOP = 2;
   localparam int ST_CMP = 3;
   localparam int ST_BRK_ERR = 4;
   localparam int ST_RST_DONE = 5;
   localparam int ST_RISE = 6;
   localparam int ST_W = 7;

   // Control bit positions
   localparam int CT_EN = 0;
   localparam int CT_RST = 1;
   localparam int CT_BSD = 2;
   localparam int CT_RISE_IRQ = 12;
   localparam int CT_W = 13;

   // Field widths and reset values
   localparam int SYNC_W = 16;
   localparam int BRK_W = 12;
   localparam int EDGE_W = 4;
   localparam int BAUD_SHIFT = 3;
   localparam logic [ST_W-1:0] STATUS_RST = 7'h00;
   localparam logic [CT_W-1:0] CTRL_RST = 13'h0000;
   localparam logic [2*EDGE_W-1:0] EDGE_RST = 8'h51;
   localparam logic [BRK_W-1:0] BRK_CMP_RST = 12'h5a0;
   localparam logic [SYNC_W-1:0] SYNC_CMP_RST = 16'hffff;

   // AXI responses
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Frame tracking states
   typedef enum logic [3:0] {
      LHS_IDLE = 4'h1,
      LHS_BRKEND = 4'h2,
      LHS_WAITSTART = 4'h4,
      LHS_MEAS = 4'h8
   } lhs_state_t;
endpackage

//--- core/lhs_sync2.sv
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the input is a pin with no relation to clk.
 */
`timescale 1ns/1ps
module lhs_sync2 (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Level
   input wire logic din,
   output logic dout
);
   logic meta_q;

   // Idle LIN bus is recessive, hence the reset value of one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

//--- core/lhs_tick_div.sv
/*
 * Divider giving a one-cycle enable pulse every DIV clocks.
 * Assumes DIV of at least 2 and at most 256.
 */
`timescale 1ns/1ps
module lhs_tick_div #(
   parameter int DIV = 5
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Enable pulse
   output logic tick
);
   logic [7:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         tick <= 1'b0;
      end else if (cnt_q == 8'(DIV - 1)) begin
         cnt_q <= 8'h00;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         tick <= 1'b0;
      end
   end
endmodule

//--- core/lhs_top.sv
/*
 * LIN slave hardware sync detector: break timer, sync byte timer,
 * read-clear status, interrupt status/mask, AXI4-Lite slave.
 * Assumes lin_rx comes straight from the transceiver pin.
 */
// The AXI4-Lite interface to the registers is this design's own decision.
// Notes on behaviour
// (RULE1) Slave only; timers cover bit rates from 1 to 20 kilobaud.
// (RULE2) Break timer steps on the low-power oscillator rate only.
// (RULE3) Sync byte timer steps on a 5 MHz enable.
// (RULE4) Sixteen-bit sync timer, run as main control configures it.
// (RULE5) Edge select register picks the start and stop falling edges.
// (RULE6) Main control and edge select together set the LIN setup.
// (RULE7) Status bit 0 sets when break timer hits break compare.
// (RULE8) Status bit 1 sets on the start condition.
// (RULE9) Status bit 2 sets on the stop condition.
// (RULE10) Status bit 3 sets when sync timer equals sync compare.
// (RULE11) Break timer overflow sets bit 4 and raises the interrupt.
// (RULE12) Status bit 5 sets when a reset command has completed.
// (RULE13) Status bit 6 sets on rising edges in bit-serial mode only.
// (RULE14) Reading the status register clears all its flags.
// (RULE15) Status bits 31 to 7 read as zero.
// (RULE16) Control bit 12 enables rise irq in LIN, disables in serial.
// (RULE17) Master sends a long break and then the sync byte.
// (RULE18) Measured sync count sets the receive baud divisor.
`timescale 1ns/1ps
module lhs_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AXI4-Lite write
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // LIN pin
   input wire logic lin_rx,
   // To UART and CPU
   output logic [lhs_pkg::SYNC_W-1:0] baud_div_q,
   output logic irq
);
   logic rx_s, rx_prev_q, fall, rise;
   logic sync_tick, lp_tick;
   logic [lhs_pkg::CT_W-1:0] ctrl_q;
   logic [2*lhs_pkg::EDGE_W-1:0] edge_q;
   logic [lhs_pkg::BRK_W-1:0] brk_cmp_q, brk_tmr_q;
   logic [lhs_pkg::SYNC_W-1:0] sync_cmp_q, sync_tmr_q;
   logic [lhs_pkg::ST_W-1:0] status_q, irq_stat_q, mask_q, ev;
   logic [lhs_pkg::EDGE_W-1:0] fall_cnt_q;
   logic rst_pend_q, rst_done_q;
   lhs_pkg::lhs_state_t state_q;
   logic en, bit_serial_mode, rise_irq_en;
   logic [31:0] awaddr_q, wdata_q, rd_d;
   logic [3:0] wstrb_q;
   logic aw_full_q, w_full_q, do_wr, do_rd, rd_status;
   logic rd_sta_q, wr_rst;
   logic [1:0] rresp_d;

   lhs_sync2 u_rx_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(lin_rx),
      .dout(rx_s)
   );

   // [RULE3]
   lhs_tick_div #(.DIV(lhs_pkg::SYNC_DIV)) u_sync_div (
      .clk(clk),
      .rst_n(rst_n),
      .tick(sync_tick)
   );

   // [RULE2]
   lhs_tick_div #(.DIV(lhs_pkg::LP_DIV)) u_lp_div (
      .clk(clk),
      .rst_n(rst_n),
      .tick(lp_tick)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rx_s;
      end
   end

   assign fall = rx_prev_q & ~rx_s;
   assign rise = ~rx_prev_q & rx_s;
   assign en = ctrl_q[lhs_pkg::CT_EN]; // [RULE6]
   assign bit_serial_mode = ctrl_q[lhs_pkg::CT_BSD];
   // Same bit, opposite sense per mode
   assign rise_irq_en = bit_serial_mode ? ~ctrl_q[lhs_pkg::CT_RISE_IRQ]
                            : ctrl_q[lhs_pkg::CT_RISE_IRQ]; // [RULE16]

   // Events of this cycle
   always_comb begin
      ev = '0;
      if (en && !rst_pend_q) begin
         ev[lhs_pkg::ST_BREAK] = (state_q == lhs_pkg::LHS_IDLE) && !bit_serial_mode
            && lp_tick && !rx_s
            && (brk_tmr_q + 12'h001 == brk_cmp_q); // [RULE7]
         ev[lhs_pkg::ST_BRK_ERR] = (state_q != lhs_pkg::LHS_MEAS)
            && !bit_serial_mode && lp_tick && !rx_s
            && (brk_tmr_q == 12'hfff); // [RULE11]
         ev[lhs_pkg::ST_START] = (state_q == lhs_pkg::LHS_WAITSTART)
            && fall
            && (fall_cnt_q + 4'h1 == edge_q[3:0]); // [RULE8] [RULE5]
         ev[lhs_pkg::ST_STOP] = (state_q == lhs_pkg::LHS_MEAS) && fall
            && (fall_cnt_q + 4'h1 == edge_q[7:4]); // [RULE9] [RULE5]
         ev[lhs_pkg::ST_CMP] = (state_q == lhs_pkg::LHS_MEAS)
            && sync_tick
            && (sync_tmr_q + 16'h0001 == sync_cmp_q); // [RULE10]
         ev[lhs_pkg::ST_RISE] = bit_serial_mode && rise; // [RULE13]
      end
      ev[lhs_pkg::ST_RST_DONE] = rst_done_q; // [RULE12]
   end

   // Frame tracking
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= lhs_pkg::LHS_IDLE;
      end else if (rst_pend_q || !en || bit_serial_mode) begin
         state_q <= lhs_pkg::LHS_IDLE;
      end else begin
         unique case (state_q)
            lhs_pkg::LHS_IDLE: begin
               if (ev[lhs_pkg::ST_BREAK]) begin
                  state_q <= lhs_pkg::LHS_BRKEND;
               end
            end
            lhs_pkg::LHS_BRKEND: begin
               if (ev[lhs_pkg::ST_BRK_ERR]) begin
                  state_q <= lhs_pkg::LHS_IDLE;
               end else if (rise) begin
                  state_q <= lhs_pkg::LHS_WAITSTART;
               end
            end
            lhs_pkg::LHS_WAITSTART: begin
               if (ev[lhs_pkg::ST_START]) begin
                  state_q <= lhs_pkg::LHS_MEAS;
               end
            end
            lhs_pkg::LHS_MEAS: begin
               if (ev[lhs_pkg::ST_STOP]) begin
                  state_q <= lhs_pkg::LHS_IDLE;
               end
            end
         endcase
      end
   end

   // Break timer counts low time; cleared by any high level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         brk_tmr_q <= '0;
      end else if (rst_pend_q || rx_s || !en || bit_serial_mode) begin
         brk_tmr_q <= '0;
      end else if (lp_tick) begin
         brk_tmr_q <= brk_tmr_q + 12'h001; // [RULE2] [RULE11]
      end
   end

   // Falling edges since end of break, start edge included
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fall_cnt_q <= '0;
      end else if (state_q == lhs_pkg::LHS_BRKEND || rst_pend_q) begin
         fall_cnt_q <= '0;
      end else if (fall) begin
         fall_cnt_q <= fall_cnt_q + 4'h1;
      end
   end

   // Sync byte timer; 16 bits at 5 MHz spans a 1 kilobaud sync byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_tmr_q <= '0;
      end else if (ev[lhs_pkg::ST_START] || rst_pend_q) begin
         sync_tmr_q <= '0; // [RULE4] [RULE1]
      end else if (state_q == lhs_pkg::LHS_MEAS && sync_tick) begin
         sync_tmr_q <= sync_tmr_q + 16'h0001; // [RULE3]
      end
   end

   // Baud divisor assumes the default eight-bit span between edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_div_q <= '0;
      end else if (ev[lhs_pkg::ST_STOP]) begin
         baud_div_q <= sync_tmr_q >> lhs_pkg::BAUD_SHIFT; // [RULE18]
      end
   end

   // Reset command: one cycle to clear, completion flag next
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pend_q <= 1'b0;
         rst_done_q <= 1'b0;
      end else begin
         rst_pend_q <= wr_rst;
         rst_done_q <= rst_pend_q; // [RULE12]
      end
   end

   // Status: set wins over the read clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= lhs_pkg::STATUS_RST;
      end else if (rd_status) begin
         status_q <= ev; // [RULE14]
      end else begin
         status_q <= status_q | ev;
      end
   end

   // Interrupt status: write one to clear; set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q
            & ~((do_wr && awaddr_q == lhs_pkg::ADDR_IRQ_STAT)
                ? wdata_q[lhs_pkg::ST_W-1:0] : 7'h00))
            | (ev & {rise_irq_en | ~rise, 6'h3f}); // [RULE16]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & mask_q); // [RULE11]
      end
   end

   // AXI write path: address and data taken in either order
   assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_rst = do_wr && awaddr_q == lhs_pkg::ADDR_CTRL
      && wstrb_q[0] && wdata_q[lhs_pkg::CT_RST];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_q <= 1'b0;
         awaddr_q <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_full_q <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w_full_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_full_q <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lhs_pkg::RESP_OK;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         unique case (awaddr_q)
            lhs_pkg::ADDR_STATUS, lhs_pkg::ADDR_CTRL, lhs_pkg::ADDR_EDGE,
            lhs_pkg::ADDR_SYNC_TMR, lhs_pkg::ADDR_BRK_TMR,
            lhs_pkg::ADDR_SYNC_CMP, lhs_pkg::ADDR_BRK_CMP,
            lhs_pkg::ADDR_IRQ_MASK, lhs_pkg::ADDR_IRQ_STAT,
            lhs_pkg::ADDR_BAUD: s_axi_bresp <= lhs_pkg::RESP_OK;
            default: s_axi_bresp <= lhs_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Writable registers; byte lane 0 and 1 cover all used bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= lhs_pkg::CTRL_RST;
         edge_q <= lhs_pkg::EDGE_RST;
         brk_cmp_q <= lhs_pkg::BRK_CMP_RST;
         sync_cmp_q <= lhs_pkg::SYNC_CMP_RST;
         mask_q <= '0;
      end else if (do_wr) begin
         unique case (awaddr_q)
            lhs_pkg::ADDR_CTRL: begin
               if (wstrb_q[0]) begin
                  ctrl_q[7:0] <= wdata_q[7:0] & 8'hfd; // Self clearing
               end
               if (wstrb_q[1]) begin
                  ctrl_q[12:8] <= wdata_q[12:8]; // [RULE6]
               end
            end
            lhs_pkg::ADDR_EDGE: begin
               if (wstrb_q[0]) begin
                  edge_q <= wdata_q[7:0]; // [RULE5]
               end
            end
            lhs_pkg::ADDR_BRK_CMP: begin
               if (wstrb_q[0]) begin
                  brk_cmp_q[7:0] <= wdata_q[7:0];
               end
               if (wstrb_q[1]) begin
                  brk_cmp_q[11:8] <= wdata_q[11:8];
               end
            end
            lhs_pkg::ADDR_SYNC_CMP: begin
               if (wstrb_q[0]) begin
                  sync_cmp_q[7:0] <= wdata_q[7:0];
               end
               if (wstrb_q[1]) begin
                  sync_cmp_q[15:8] <= wdata_q[15:8];
               end
            end
            lhs_pkg::ADDR_IRQ_MASK: begin
               if (wstrb_q[0]) begin
                  mask_q <= wdata_q[lhs_pkg::ST_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // AXI read path
   assign do_rd = s_axi_arvalid && s_axi_arready;
   assign rd_status = do_rd && s_axi_araddr == lhs_pkg::ADDR_STATUS;

   always_comb begin
      rd_d = 32'h0000_0000;
      rresp_d = lhs_pkg::RESP_OK;
      unique case (s_axi_araddr)
         lhs_pkg::ADDR_STATUS: rd_d[lhs_pkg::ST_W-1:0] = status_q; // [RULE15]
         lhs_pkg::ADDR_CTRL: rd_d[lhs_pkg::CT_W-1:0] = ctrl_q;
         lhs_pkg::ADDR_EDGE: rd_d[7:0] = edge_q;
         lhs_pkg::ADDR_SYNC_TMR: rd_d[15:0] = sync_tmr_q;
         lhs_pkg::ADDR_BRK_TMR: rd_d[11:0] = brk_tmr_q;
         lhs_pkg::ADDR_SYNC_CMP: rd_d[15:0] = sync_cmp_q;
         lhs_pkg::ADDR_BRK_CMP: rd_d[11:0] = brk_cmp_q;
         lhs_pkg::ADDR_IRQ_MASK: rd_d[lhs_pkg::ST_W-1:0] = mask_q;
         lhs_pkg::ADDR_IRQ_STAT: rd_d[lhs_pkg::ST_W-1:0] = irq_stat_q;
         lhs_pkg::ADDR_BAUD: rd_d[15:0] = baud_div_q;
         default: rresp_d = lhs_pkg::RESP_SLVERR;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= lhs_pkg::RESP_OK;
         rd_sta_q <= 1'b0;
      end else if (do_rd) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_d;
         s_axi_rresp <= rresp_d;
         rd_sta_q <= rd_status;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_break_flag_set: assert property ( // [RULE7]
      ev[lhs_pkg::ST_BREAK] |=> status_q[lhs_pkg::ST_BREAK]
         && state_q == lhs_pkg::LHS_BRKEND)
      else $error("break flag or state missing");
   a_start_flag_set: assert property ( // [RULE8]
      ev[lhs_pkg::ST_START] |=> status_q[lhs_pkg::ST_START]
         && sync_tmr_q == 16'h0000)
      else $error("start flag missing");
   a_stop_baud_update: assert property ( // [RULE18]
      ev[lhs_pkg::ST_STOP] |=> status_q[lhs_pkg::ST_STOP]
         && baud_div_q == $past(sync_tmr_q) >> lhs_pkg::BAUD_SHIFT)
      else $error("stop flag or baud divisor wrong");
   a_cmp_flag_set: assert property ( // [RULE10]
      (state_q == lhs_pkg::LHS_MEAS && sync_tick && en && !rst_pend_q
         && sync_tmr_q + 16'h0001 == sync_cmp_q)
      |=> status_q[lhs_pkg::ST_CMP])
      else $error("compare flag missing");
   a_overflow_irq: assert property ( // [RULE11]
      (ev[lhs_pkg::ST_BRK_ERR] && mask_q[lhs_pkg::ST_BRK_ERR])
      |=> status_q[lhs_pkg::ST_BRK_ERR] ##1 irq)
      else $error("overflow did not raise irq");
   a_reset_done_flag: assert property ( // [RULE12]
      wr_rst |=> rst_pend_q ##2 status_q[lhs_pkg::ST_RST_DONE])
      else $error("reset completion missing");
   a_rise_bsd_only: assert property ( // [RULE13]
      $rose(status_q[lhs_pkg::ST_RISE]) |-> $past(bit_serial_mode))
      else $error("rise flag outside serial mode");
   a_status_read_clear: assert property ( // [RULE14]
      (rd_status && ev == 7'h00) |=> status_q == 7'h00)
      else $error("status not cleared by read");
   a_status_resv_zero: assert property ( // [RULE15]
      (s_axi_rvalid && rd_sta_q) |-> s_axi_rdata[31:7] == 25'h0)
      else $error("reserved status bits not zero");
   a_sync_tick_rate: assert property ( // [RULE3]
      sync_tick |=> !sync_tick [*4] ##1 sync_tick)
      else $error("sync tick not at 5 MHz");

   c_break_seen: cover property (ev[lhs_pkg::ST_BREAK]);
   c_full_measure: cover property (ev[lhs_pkg::ST_STOP]);
   c_break_error: cover property (ev[lhs_pkg::ST_BRK_ERR]);
endmodule

//--- tb/lhs_lin_master.sv
/*
 * Behavioural LIN master node driving the single bus wire.
 * Assumes an on-chip pull-up, so the wire idles recessive high.
 */
`timescale 1ns/1ps
module lhs_lin_master (
   // Clock
   input wire logic clk,
   // Bus wire
   output logic lin
);
   initial begin
      lin = 1'b1;
   end
   // Level changes just after an edge, held n clocks
   task automatic hold(input logic lvl, input int n);
      lin <= lvl;
      repeat (n) @(posedge clk);
   endtask
   // Break, delimiter, then 0x55 framed lsb first
   task automatic send_frame(input int brk, input int bit_clks);
      logic [9:0] frame;
      frame = {1'b1, 8'h55, 1'b0};
      hold(1'b0, brk);
      hold(1'b1, bit_clks);
      for (int i = 0; i < 10; i++) begin
         hold(frame[i], bit_clks);
      end
   endtask
   // One low pulse, giving one rising edge
   task automatic pulse(input int n);
      hold(1'b0, n);
      hold(1'b1, n);
   endtask
endmodule

//--- tb/tb.sv
/*
 * Self-checking bench for lhs_top: AXI4-Lite master tasks, LIN master
 * model on lin_rx, one task per scenario.
 * Assumes the package, design and master model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
      end \
   end
module tb;
   localparam int BIT = 1250;
   logic clk, rst_n, lin_rx, irq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
   logic [31:0] rd_data;
   logic [15:0] baud_div_q;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   lhs_top lhs_top_inst (.clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .lin_rx(lin_rx),
      .baud_div_q(baud_div_q), .irq(irq));
   lhs_lin_master lhs_lin_master_inst (.clk(clk), .lin(lin_rx));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic wrap_up();
      $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // One frame of 0x55 at 20 kbaud stays well under this
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         fails++;
         wrap_up();
      end
   end
   // Address and data offered together, each released when taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (n < 200) begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            wr_resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (n >= 200) fails++;
   endtask
   task automatic rd(input logic [31:0] a);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (n < 200) begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (n >= 200) fails++;
   endtask
   task automatic t_reset();
      rd(lhs_pkg::ADDR_STATUS);
      `CHK("status", 32'h00000000, rd_data);
      `CHK("status resp", lhs_pkg::RESP_OK, rd_resp);
      rd(lhs_pkg::ADDR_CTRL);
      `CHK("ctrl", 32'h00000000, rd_data);
      rd(lhs_pkg::ADDR_EDGE);
      `CHK("edge", 32'h00000051, rd_data);
      rd(32'hffff07f0);
      `CHK("unmapped", lhs_pkg::RESP_SLVERR, rd_resp);
      wr(32'hffff07f0, 32'h00000000);
      `CHK("unmapped write", lhs_pkg::RESP_SLVERR, wr_resp);
      $display("test reset done");
   endtask
   // Compare lies inside the measurement, so bit 3 fires too
   task automatic t_frame();
      logic [15:0] eb;
      eb = 16'((8 * BIT / lhs_pkg::SYNC_DIV) >> lhs_pkg::BAUD_SHIFT);
      wr(lhs_pkg::ADDR_SYNC_CMP, 32'h00000064);
      wr(lhs_pkg::ADDR_BRK_CMP, 32'h00000004);
      wr(lhs_pkg::ADDR_IRQ_MASK, 32'h0000000f);
      wr(lhs_pkg::ADDR_CTRL, 32'h00000001);
      lhs_lin_master_inst.send_frame(1000, BIT);
      rd(lhs_pkg::ADDR_STATUS);
      `CHK("status", 32'h0000000f, rd_data);
      `CHK("baud", 1'b1, baud_div_q >= eb - 1 && baud_div_q <= eb + 1);
      `CHK("irq", 1'b1, irq);
      rd(lhs_pkg::ADDR_STATUS);
      `CHK("status", 32'h00000000, rd_data);
      rd(lhs_pkg::ADDR_IRQ_STAT);
      `CHK("irq status", 32'h0000000f, rd_data);
      wr(lhs_pkg::ADDR_IRQ_STAT, 32'h0000000f);
      repeat (3) @(posedge clk);
      `CHK("irq", 1'b0, irq);
      $display("test frame done");
   endtask
   task automatic t_rstcmd();
      wr(lhs_pkg::ADDR_CTRL, 32'h00000003);
      rd(lhs_pkg::ADDR_CTRL);
      `CHK("ctrl reset bit", 1'b0, rd_data[1]);
      rd(lhs_pkg::ADDR_STATUS);
      `CHK("status", 32'h00000020, rd_data);
      $display("test reset command done");
   endtask
   // Bit 12 has opposite sense in bit-serial mode
   task automatic t_serial();
      wr(lhs_pkg::ADDR_IRQ_MASK, 32'h00000040);
      wr(lhs_pkg::ADDR_CTRL, 32'h00001005);
      lhs_lin_master_inst.pulse(50);
      rd(lhs_pkg::ADDR_STATUS);
      `CHK("rise flag", 1'b1, rd_data[6]);
      `CHK("irq", 1'b0, irq);
      wr(lhs_pkg::ADDR_CTRL, 32'h00000005);
      lhs_lin_master_inst.pulse(50);
      `CHK("irq", 1'b1, irq);
      wr(lhs_pkg::ADDR_IRQ_STAT, 32'h00000040);
      repeat (3) @(posedge clk);
      `CHK("irq", 1'b0, irq);
      $display("test serial done");
   endtask
   initial begin
      rst_n = 1'b0;
      s_axi_awaddr = 32'h00000000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 32'h00000000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_frame();
      t_rstcmd();
      t_serial();
      wrap_up();
   end
endmodule
